// File: hw/vic_pkg.sv
/*
 * Shared constants of the vectored interrupt controller: register indices,
 * field positions, reset values, source numbers and the sequencer states.
 * Assumes an APB slave with 32-bit data; byte address is four times the index.
 */
package vic_pkg;

    // Source count and request numbers
    localparam int VIC_NUM_SRC = 6;
    localparam logic [2:0] VIC_SRC_PIN_B = 3'h0;
    localparam logic [2:0] VIC_SRC_PIN_C = 3'h1;
    localparam logic [2:0] VIC_SRC_PIN_A = 3'h2;
    localparam logic [2:0] VIC_SRC_T16 = 3'h3;
    localparam logic [2:0] VIC_SRC_T8 = 3'h4;
    localparam logic [2:0] VIC_SRC_LVD = 3'h5;

    // Register indices (byte address = index * 4)
    localparam logic [9:0] VIC_IDX_PINS = 10'h0F0;
    localparam logic [9:0] VIC_IDX_CFG = 10'h0F1;
    localparam logic [9:0] VIC_IDX_EVT_STAT = 10'h0F4;
    localparam logic [9:0] VIC_IDX_EVT_CLR = 10'h0F5;
    localparam logic [9:0] VIC_IDX_EVT_EN = 10'h0F6;
    localparam logic [9:0] VIC_IDX_VEC = 10'h0F8;
    localparam logic [9:0] VIC_IDX_PRIO = 10'h0F9;
    localparam logic [9:0] VIC_IDX_REQ = 10'h0FA;
    localparam logic [9:0] VIC_IDX_MASK = 10'h0FB;

    // Field positions
    localparam int VIC_REQ_EDGE_LSB = 6;
    localparam int VIC_MASK_GIE_BIT = 7;
    localparam int VIC_PINS_A_BIT = 1;
    localparam int VIC_PINS_B_BIT = 2;
    localparam int VIC_PINS_C_BIT = 3;
    localparam int VIC_CFG_ANALOG_BIT = 0;
    localparam int VIC_EVT_SERVED_BIT = 0;
    localparam int VIC_EVT_POLLED_BIT = 1;

    // Reset values
    localparam logic [5:0] VIC_PEND_RST = 6'h00;
    localparam logic [1:0] VIC_EDGE_RST = 2'h0;
    localparam logic [5:0] VIC_MASK_RST = 6'h00;
    localparam logic [2:0] VIC_PRIO_RST = 3'h0;
    localparam logic [1:0] VIC_EVT_RST = 2'h0;

    // Edge select codes held in the two top request bits
    localparam logic [1:0] VIC_EDGE_FF = 2'h0;
    localparam logic [1:0] VIC_EDGE_BOTH = 2'h3;

    // Interrupt machine cycle sequencer
    typedef enum logic [2:0] {
        VIC_IDLE,
        VIC_SAVE,
        VIC_FETCH_HI,
        VIC_FETCH_LO
    } vic_state_e;

    // True for every index that the slave answers
    function automatic logic vicIsMapped(input logic [9:0] idx);
        vicIsMapped = (idx == VIC_IDX_PINS) || (idx == VIC_IDX_CFG) || (idx == VIC_IDX_EVT_STAT) ||
            (idx == VIC_IDX_EVT_CLR) || (idx == VIC_IDX_EVT_EN) || (idx == VIC_IDX_VEC) ||
            (idx == VIC_IDX_PRIO) || (idx == VIC_IDX_REQ) || (idx == VIC_IDX_MASK);
    endfunction

endpackage

// File: hw/vic_edge_detect.sv
/*
 * Single-line edge detector with separate rising and falling enables.
 * Assumes the input level is already synchronous to clock.
 */
`timescale 1ns/1ps
module vic_edge_detect
    import vic_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic level,
    input wire logic riseEn,
    input wire logic fallEn,
    output logic detect
);

    typedef struct packed {
        logic armed;
        logic prev;
    } vic_edge_s;

    vic_edge_s st_r;
    vic_edge_s st_nxt;

    // Armed only after one sample, so reset never fakes an edge
    always_comb begin
        st_nxt = st_r;
        st_nxt.armed = 1'b1;
        st_nxt.prev = level;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Compares last sample with the present one
    assign detect = st_r.armed && ((riseEn && !st_r.prev && level) || (fallEn && st_r.prev && !level));

endmodule

// File: hw/vic_ctrl.sv
/*
 * Vectored interrupt controller: six latched requests, programmable priority,
 * interrupt machine cycle with a two-byte vector fetch, APB register slave.
 * Assumes pins and event pulses synchronous to clock, and a program memory
 * port that answers a held request with memValid some cycles later.
 */
`timescale 1ns/1ps
module vic_ctrl
    import vic_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic edgePinA,
    input wire logic edgePinB,
    input wire logic levelPinC,
    input wire logic compInOne,
    input wire logic compInTwo,
    input wire logic timerInputEvt,
    input wire logic timerSixteenEvt,
    input wire logic timerEightEvt,
    input wire logic lowVoltageEvt,
    input wire logic coreBoundary,
    input wire logic coreReturn,
    output logic intCycle,
    output logic saveContext,
    output logic memReq,
    output logic [ADDR_W-1:0] memAddr,
    input wire logic [7:0] memData,
    input wire logic memValid,
    output logic vectorLoad,
    output logic [15:0] vector,
    output logic smrLevelC,
    output logic irq
);

    // The vector table sits in the lowest twelve bytes
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_width
        $error("vic_ctrl: ADDR_W must lie between 4 and 32");
    end

    typedef struct packed {
        logic [31:0] prdata;
        logic [5:0] pend;
        logic [1:0] edgeSel;
        logic [5:0] mask;
        logic gie;
        logic [2:0] prio;
        logic analog;
        logic [1:0] evtStat;
        logic [1:0] evtEn;
        vic_state_e state;
        logic [2:0] src;
        logic [7:0] vecHi;
        logic [15:0] vector;
        logic memReq;
        logic [ADDR_W-1:0] memAddr;
        logic saveCtx;
        logic vecLoad;
        logic smrC;
    } vic_ctrl_s;

    vic_ctrl_s st_r;
    vic_ctrl_s st_nxt;

    logic [9:0] regIdx;
    logic aligned;
    logic mapped;
    logic rdSetup;
    logic wrAcc;
    logic wrReq;
    logic src0Level;
    logic src2Level;
    logic det0;
    logic det1;
    logic det2;
    logic [5:0] newReq;
    logic [5:0] enabledPend;
    logic grant;
    logic [2:0] grantSrc;

    // Rotating order: prio names the top source, the rest follow upward
    function automatic logic [2:0] vicPick(input logic [5:0] req, input logic [2:0] top);
        logic [2:0] pick;
        int idx;
        pick = 3'h0;
        for (int i = VIC_NUM_SRC - 1; i >= 0; i--) begin
            idx = (int'(top) + i) % VIC_NUM_SRC;
            if (req[idx]) begin
                pick = 3'(idx);
            end
        end
        return pick;
    endfunction

    // APB decode; zero wait states, so every access ends in one access cycle
    assign regIdx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign mapped = aligned && vicIsMapped(regIdx);
    assign rdSetup = psel && !penable && !pwrite;
    assign wrAcc = psel && penable && pwrite && mapped;
    assign wrReq = wrAcc && (regIdx == VIC_IDX_REQ);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Comparators replace the pins as sources in analog mode
    assign src0Level = st_r.analog ? compInTwo : edgePinB;
    assign src2Level = st_r.analog ? compInOne : edgePinA;

    // Edge select decode: 00 F/F, 01 F/R, 10 R/F, 11 both
    vic_edge_detect u_det0 (
        .clock(clock), .srst(srst), .level(src0Level),
        .riseEn(st_r.edgeSel[0]), .fallEn(!st_r.edgeSel[0] || st_r.edgeSel[1]),
        .detect(det0)
    );
    vic_edge_detect u_det1 (
        .clock(clock), .srst(srst), .level(levelPinC),
        .riseEn(1'b0), .fallEn(1'b1),
        .detect(det1)
    );
    vic_edge_detect u_det2 (
        .clock(clock), .srst(srst), .level(src2Level),
        .riseEn(st_r.edgeSel[1]), .fallEn(!st_r.edgeSel[1] || st_r.edgeSel[0]),
        .detect(det2)
    );

    // Source map; request 1 is withheld while port 3 is analog
    assign newReq[VIC_SRC_PIN_B] = det0;
    assign newReq[VIC_SRC_PIN_C] = det1 && !st_r.analog;
    assign newReq[VIC_SRC_PIN_A] = det2 || timerInputEvt;
    assign newReq[VIC_SRC_T16] = timerSixteenEvt;
    assign newReq[VIC_SRC_T8] = timerEightEvt;
    assign newReq[VIC_SRC_LVD] = lowVoltageEvt;

    // Grant only at an instruction boundary with interrupts enabled
    assign enabledPend = st_r.pend & st_r.mask;
    assign grantSrc = vicPick(enabledPend, st_r.prio);
    assign grant = (st_r.state == VIC_IDLE) && st_r.gie && coreBoundary && (enabledPend != 6'h00);

    // Next state: register writes, request latching, machine cycle sequencer
    always_comb begin
        st_nxt = st_r;
        st_nxt.saveCtx = 1'b0;
        st_nxt.vecLoad = 1'b0;
        st_nxt.smrC = st_r.analog && levelPinC;
        st_nxt.prdata = 32'h0000_0000;

        // Read data captured in the setup cycle, shown in the access cycle
        if (rdSetup && aligned) begin
            if (regIdx == VIC_IDX_REQ) begin
                st_nxt.prdata = {24'h00_0000, st_r.edgeSel, st_r.pend};
            end else if (regIdx == VIC_IDX_MASK) begin
                st_nxt.prdata = {24'h00_0000, st_r.gie, 1'b0, st_r.mask};
            end else if (regIdx == VIC_IDX_PRIO) begin
                st_nxt.prdata = {29'h0000_0000, st_r.prio};
            end else if (regIdx == VIC_IDX_PINS) begin
                st_nxt.prdata[VIC_PINS_A_BIT] = edgePinA;
                st_nxt.prdata[VIC_PINS_B_BIT] = edgePinB;
                st_nxt.prdata[VIC_PINS_C_BIT] = levelPinC && !st_r.analog;
            end else if (regIdx == VIC_IDX_CFG) begin
                st_nxt.prdata[VIC_CFG_ANALOG_BIT] = st_r.analog;
            end else if (regIdx == VIC_IDX_EVT_STAT) begin
                st_nxt.prdata = {30'h0000_0000, st_r.evtStat};
            end else if (regIdx == VIC_IDX_EVT_EN) begin
                st_nxt.prdata = {30'h0000_0000, st_r.evtEn};
            end else if (regIdx == VIC_IDX_VEC) begin
                st_nxt.prdata = {16'h0000, st_r.vector};
            end else begin
                st_nxt.prdata = 32'h0000_0000;
            end
        end

        // Writes land at the access edge
        if (wrAcc) begin
            if (regIdx == VIC_IDX_REQ) begin
                st_nxt.pend = pwdata[5:0];
                st_nxt.edgeSel = pwdata[VIC_REQ_EDGE_LSB +: 2];
            end else if (regIdx == VIC_IDX_MASK) begin
                st_nxt.mask = pwdata[5:0];
                st_nxt.gie = pwdata[VIC_MASK_GIE_BIT];
            end else if (regIdx == VIC_IDX_PRIO) begin
                st_nxt.prio = pwdata[2:0];
            end else if (regIdx == VIC_IDX_CFG) begin
                st_nxt.analog = pwdata[VIC_CFG_ANALOG_BIT];
            end else if (regIdx == VIC_IDX_EVT_CLR) begin
                st_nxt.evtStat = st_r.evtStat & ~pwdata[1:0];
            end else if (regIdx == VIC_IDX_EVT_EN) begin
                st_nxt.evtEn = pwdata[1:0];
            end
        end

        // Return from service re-enables; a same-cycle grant still wins
        if (coreReturn) begin
            st_nxt.gie = 1'b1;
        end

        // Sequencer
        case (st_r.state)
            VIC_IDLE: begin
                if (grant) begin
                    st_nxt.pend[grantSrc] = 1'b0;
                    st_nxt.gie = 1'b0;
                    st_nxt.src = grantSrc;
                    st_nxt.saveCtx = 1'b1;
                    st_nxt.state = VIC_SAVE;
                end
            end
            VIC_SAVE: begin
                st_nxt.memReq = 1'b1;
                st_nxt.memAddr = {{(ADDR_W - 4){1'b0}}, st_r.src, 1'b0};
                st_nxt.state = VIC_FETCH_HI;
            end
            VIC_FETCH_HI: begin
                if (memValid) begin
                    st_nxt.vecHi = memData;
                    st_nxt.memAddr = {{(ADDR_W - 4){1'b0}}, st_r.src, 1'b1};
                    st_nxt.state = VIC_FETCH_LO;
                end
            end
            VIC_FETCH_LO: begin
                if (memValid) begin
                    st_nxt.vector = {st_r.vecHi, memData};
                    st_nxt.vecLoad = 1'b1;
                    st_nxt.memReq = 1'b0;
                    st_nxt.evtStat[VIC_EVT_SERVED_BIT] = 1'b1;
                    st_nxt.state = VIC_IDLE;
                end
            end
            default: begin
                st_nxt.state = VIC_IDLE;
            end
        endcase

        // New edges set last so they beat a clear in the same cycle
        st_nxt.pend = st_nxt.pend | newReq;
        if ((newReq & ~st_r.mask) != 6'h00) begin
            st_nxt.evtStat[VIC_EVT_POLLED_BIT] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
            st_r.pend <= VIC_PEND_RST;
            st_r.edgeSel <= VIC_EDGE_RST;
            st_r.mask <= VIC_MASK_RST;
            st_r.prio <= VIC_PRIO_RST;
            st_r.evtStat <= VIC_EVT_RST;
            st_r.evtEn <= VIC_EVT_RST;
            st_r.state <= VIC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign prdata = st_r.prdata;
    assign intCycle = (st_r.state != VIC_IDLE);
    assign saveContext = st_r.saveCtx;
    assign memReq = st_r.memReq;
    assign memAddr = st_r.memAddr;
    assign vectorLoad = st_r.vecLoad;
    assign vector = st_r.vector;
    assign smrLevelC = st_r.smrC;
    assign irq = (st_r.evtStat & st_r.evtEn) != 2'h0;

    // Checks of the documented behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_grant_gie_off: assert property (grant && !coreReturn |=> !st_r.gie && st_r.state == VIC_SAVE)
        else $error("grant did not disable interrupts");
    chk_save_then_fetch: assert property (grant |=> saveContext ##1 (memReq && !saveContext))
        else $error("context save not followed by fetch");
    chk_fetch_even_addr: assert property (st_r.state == VIC_FETCH_HI
        |-> memReq && memAddr[3:0] == {st_r.src, 1'b0})
        else $error("first vector byte not at even address");
    chk_vector_halves: assert property (st_r.state == VIC_FETCH_LO && memValid
        |=> vectorLoad && vector == {$past(st_r.vecHi), $past(memData)})
        else $error("vector halves assembled wrongly");
    chk_pend_held: assert property ($fell(st_r.pend[3]) |-> $past(wrReq) || $past(grant && grantSrc == 3'h3))
        else $error("request dropped without service or clear");
    chk_irq1_falling: assert property (newReq[VIC_SRC_PIN_C] |-> !levelPinC && $past(levelPinC))
        else $error("request 1 raised without falling edge");
    chk_masked_recorded: assert property (det0 && !st_r.mask[0] |=> st_r.pend[0])
        else $error("masked request not recorded");
    chk_prio_top_wins: assert property (grant && st_r.prio < 3'h6 && enabledPend[st_r.prio]
        |-> grantSrc == st_r.prio)
        else $error("top priority source not chosen");
    chk_edge_sel_ff: assert property (det0 && st_r.edgeSel == VIC_EDGE_FF |-> !src0Level)
        else $error("request 0 taken on rising edge in falling mode");
    chk_analog_divert: assert property (st_r.analog && !wrReq && !st_r.pend[1] && !$past(st_r.pend[1])
        |=> !st_r.pend[1])
        else $error("request 1 raised in analog mode");
    chk_pin_poll: assert property (rdSetup && aligned && regIdx == VIC_IDX_PINS
        |=> prdata[2:1] == $past({edgePinB, edgePinA}))
        else $error("pin levels not readable");

    // Grant choice, fetch address bounds, edge modes and comparator routing
    chk_grant_enabled: assert property (grant |-> st_r.mask[grantSrc] && st_r.pend[grantSrc])
        else $error("granted source not pending and enabled");
    chk_grant_clears_req: assert property (grant && !wrReq && newReq == 6'h00
        |=> st_r.pend == ($past(st_r.pend) & ~(6'h01 << $past(grantSrc))))
        else $error("granted request not cleared alone");
    chk_src_in_range: assert property (st_r.state != VIC_IDLE |-> st_r.src < 3'h6)
        else $error("machine cycle source out of range");
    chk_fetch_odd_addr: assert property (st_r.state == VIC_FETCH_LO
        |-> memReq && memAddr[3:0] == {st_r.src, 1'b1})
        else $error("second vector byte not at odd address");
    chk_vec_table_range: assert property (memReq |-> memAddr[3:0] < 4'hC && (memAddr >> 4) == '0)
        else $error("vector fetch outside the twelve table bytes");
    chk_edge_sel_fr: assert property (det0 && st_r.edgeSel == 2'h1 |-> src0Level)
        else $error("request 0 taken on falling edge in rising mode");
    chk_edge_sel_req2: assert property (det2 && st_r.edgeSel != VIC_EDGE_BOTH
        |-> src2Level == st_r.edgeSel[1])
        else $error("request 2 taken on the wrong edge");
    chk_comp_one_map: assert property (st_r.analog && $past(st_r.analog) && det2
        |-> compInOne != $past(compInOne))
        else $error("request 2 edge without comparator one change");
    chk_comp_two_map: assert property (st_r.analog && $past(st_r.analog) && det0
        |-> compInTwo != $past(compInTwo))
        else $error("request 0 edge without comparator two change");

endmodule

// File: sim/vic_mem_model.sv
/*
 * Program memory partner of the interrupt controller: answers vector fetches.
 * Assumes memReq held through both bytes and memAddr stepping once per byte.
 */
`timescale 1ns/1ps
module vic_mem_model
    import vic_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [1:0] latency,
    input wire logic memReq,
    input wire logic [ADDR_W-1:0] memAddr,
    output logic [7:0] memData,
    output logic memValid
);
    int waitCnt;
    logic [7:0] lastByte;

    // Byte image of the vector table, a scramble of the address
    function automatic logic [7:0] romByte(input logic [ADDR_W-1:0] a);
        return 8'hC3 ^ (8'(a) * 8'h25);
    endfunction

    // Slow answers stretch every byte; bus shows inverted data when idle
    assign memValid = memReq && (waitCnt >= int'(latency));
    assign memData = memValid ? romByte(memAddr) : ~lastByte;

    // Wait counter restarts after each byte handed over
    always @(posedge clock) begin
        if (srst || !memReq || memValid) begin
            waitCnt <= 0;
        end else begin
            waitCnt <= waitCnt + 1;
        end
        if (memValid) begin
            lastByte <= memData;
        end
    end
endmodule

// File: sim/vic_ctrl_bench.sv
/*
 * Self-checking bench of the vectored interrupt controller.
 * Assumes an APB slave on the design side and the program memory partner model.
 */
`timescale 1ns/1ps
module vic_ctrl_bench
    import vic_pkg::*;
;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata, r, seed = 32'h0001848F;
    logic pready, pslverr, rerr, intCycle, saveContext, memReq, memValid, vectorLoad, smrLevelC, irq;
    logic pinA = 1, pinB = 1, pinC = 1, cmp1 = 1, cmp2 = 1, timer_input_pin = 0, t16 = 0, t8 = 0, low_voltage_detector = 0;
    logic coreBoundary = 0, coreReturn = 0;
    logic [1:0] latency = 2'h0;
    logic [15:0] memAddr, vector;
    logic [7:0] memData;
    logic [5:0] p;
    int n_errors = 0, n_checks = 0, pend, w, top, k, saves;

    // Free-running 125 MHz clock
    always #4 clock = ~clock;

    vic_ctrl #(.ADDR_W(16)) dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .edgePinA(pinA), .edgePinB(pinB), .levelPinC(pinC), .compInOne(cmp1),
        .compInTwo(cmp2), .timerInputEvt(timer_input_pin), .timerSixteenEvt(t16), .timerEightEvt(t8),
        .lowVoltageEvt(low_voltage_detector), .coreBoundary(coreBoundary), .coreReturn(coreReturn),
        .intCycle(intCycle), .saveContext(saveContext), .memReq(memReq), .memAddr(memAddr),
        .memData(memData), .memValid(memValid), .vectorLoad(vectorLoad), .vector(vector),
        .smrLevelC(smrLevelC), .irq(irq));
    vic_mem_model #(.ADDR_W(16)) mem (.clock(clock), .srst(srst), .latency(latency),
        .memReq(memReq), .memAddr(memAddr), .memData(memData), .memValid(memValid));

    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] expByte(input logic [7:0] a);
        return 8'hC3 ^ (a * 8'h25);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, then lets an idle edge pass
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // No back-to-back reassignment of psel in one time step
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        check(rdata, exp);
        check(32'(rerr), 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run length
    initial begin
        tick(20000);
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        tick(6);
        srst <= 1'h0;
        tick(1);
        rdchk(VIC_IDX_REQ, 32'h0);
        rdchk(VIC_IDX_MASK, 32'h0);
        rdchk(VIC_IDX_PRIO, 32'h0);
        rdchk(VIC_IDX_VEC, 32'h0);
        apb(1'h0, 10'h0F2, 32'h0);
        check({rdata[30:0], rerr}, 32'h1);
        // Every edge select code, falling then rising on all pins
        for (int s = 0; s < 4; s++) begin
            for (int dir = 0; dir < 2; dir++) begin
                apb(1'h1, VIC_IDX_REQ, 32'(s) << 6);
                pinA <= 1'(dir);
                pinB <= 1'(dir);
                pinC <= 1'(dir);
                tick(2);
                pend = (dir ? s / 2 : int'(s != 2)) * 4 + (1 - dir) * 2 + (dir ? s % 2 : int'(s != 1));
                rdchk(VIC_IDX_REQ, 32'((s << 6) + pend));
            end
        end
        // Pin levels visible to polling
        for (int i = 0; i < 4; i++) begin
            r = nextRand();
            pinA <= r[0];
            pinB <= r[1];
            pinC <= r[2];
            tick(1);
            rdchk(VIC_IDX_PINS, {28'h0, r[2:0], 1'h0});
        end
        // Timer and voltage pulses, masked and polled
        pinA <= 1'h1;
        pinB <= 1'h1;
        pinC <= 1'h1;
        tick(1);
        apb(1'h1, VIC_IDX_MASK, 32'h80);
        apb(1'h1, VIC_IDX_REQ, 32'h0);
        apb(1'h1, VIC_IDX_EVT_CLR, 32'h3);
        coreBoundary <= 1'h1;
        pend = 0;
        for (int i = 0; i < 4; i++) begin
            {timer_input_pin, t16, t8, low_voltage_detector} <= 4'h8 >> i;
            tick(1);
            {timer_input_pin, t16, t8, low_voltage_detector} <= 4'h0;
            tick(1);
            pend |= (i == 0) ? 4 : (8 << (i - 1));
            rdchk(VIC_IDX_REQ, 32'(pend));
        end
        check(32'(intCycle), 32'h0);
        rdchk(VIC_IDX_EVT_STAT, 32'h2);
        check(32'(irq), 32'h0);
        apb(1'h1, VIC_IDX_EVT_EN, 32'h2);
        tick(1);
        check(32'(irq), 32'h1);
        apb(1'h1, VIC_IDX_EVT_CLR, 32'h2);
        tick(1);
        check(32'(irq), 32'h0);
        coreBoundary <= 1'h0;
        // Analog mode: comparators feed requests 2 and 0, pin C diverted
        apb(1'h1, VIC_IDX_CFG, 32'h1);
        apb(1'h1, VIC_IDX_REQ, 32'h0);
        cmp1 <= 1'h0;
        cmp2 <= 1'h0;
        pinC <= 1'h0;
        tick(2);
        rdchk(VIC_IDX_REQ, 32'h5);
        check(32'(smrLevelC), 32'h0);
        pinC <= 1'h1;
        cmp1 <= 1'h1;
        cmp2 <= 1'h1;
        tick(2);
        check(32'(smrLevelC), 32'h1);
        rdchk(VIC_IDX_PINS, 32'h6);
        apb(1'h1, VIC_IDX_CFG, 32'h0);
        // Granted vectors under random pending sets and priority tops
        apb(1'h1, VIC_IDX_EVT_EN, 32'h1);
        apb(1'h1, VIC_IDX_MASK, 32'hBF);
        for (int i = 0; i < 8; i++) begin
            r = nextRand();
            p = (r[5:0] == 6'h0) ? 6'h21 : r[5:0];
            top = int'(r[10:8]);
            latency <= r[13:12];
            apb(1'h1, VIC_IDX_PRIO, 32'(top));
            apb(1'h1, VIC_IDX_REQ, 32'(p));
            w = 0;
            for (int j = 5; j >= 0; j--) begin
                if (p[(top % 6 + j) % 6]) begin
                    w = (top % 6 + j) % 6;
                end
            end
            coreBoundary <= 1'h1;
            k = 0;
            saves = 0;
            do begin
                @(posedge clock);
                k++;
                saves += int'(saveContext === 1'h1);
            end while (vectorLoad !== 1'h1 && k < 60);
            coreBoundary <= 1'h0;
            check(32'(vectorLoad), 32'h1);
            check(32'(vector), {16'h0, expByte(8'(2 * w)), expByte(8'(2 * w + 1))});
            check(32'(saves), 32'h1);
            rdchk(VIC_IDX_REQ, 32'(p & ~(6'h1 << w)));
            check(32'(irq), 32'h1);
            apb(1'h1, VIC_IDX_EVT_CLR, 32'h1);
            coreBoundary <= 1'h1;
            tick(4);
            check({31'h0, intCycle | irq}, 32'h0);
            coreBoundary <= 1'h0;
            coreReturn <= 1'h1;
            tick(1);
            coreReturn <= 1'h0;
            tick(1);
        end
        print_verdict();
    end
endmodule
